// ### logic/cns_consts.svh
`ifndef CNS_CONSTS_SVH
`define CNS_CONSTS_SVH

// Register byte offsets
`define CNS_A_CTRL 8'h00
`define CNS_A_ROT 8'h04
`define CNS_A_SDLY 8'h08
`define CNS_A_WDL 8'h0C
`define CNS_A_LIM0 8'h10
`define CNS_A_LIM1 8'h14
`define CNS_A_LIM2 8'h18
`define CNS_A_LIM3 8'h1C
`define CNS_A_STAT 8'h24
`define CNS_A_ASGN 8'h28
`define CNS_A_USTART 8'h2C

// Control bit positions
`define CNS_B_NET_ON 0
`define CNS_B_SEQ 1
`define CNS_B_RECONF 2
`define CNS_B_RESTART 3
`define CNS_B_TAKEOVER 4
`define CNS_B_INCL 5
`define CNS_B_WD_EN 6
`define CNS_B_START 7
`define CNS_B_STOP 8
`define CNS_ID_LSB 9
`define CNS_ID_MSB 11

// Status bit positions
`define CNS_S_E45 8
`define CNS_S_RUN 9
`define CNS_S_TAKE 10
`define CNS_S_FALL 11
`define CNS_S_MEM_LSB 12
`define CNS_S_TTR_LSB 16

// Reset values
`define CNS_CTRL_RST 12'h002
`define CNS_ROT_RST 16'h0E10
`define CNS_SDLY_RST 16'h000A
`define CNS_WDL_RST 16'h003C
`define CNS_TTR_RST 16'h0E10

// Timing
`define CNS_CLK_NS 4
`define CNS_SEC_NS 1000000000
`define CNS_TICK_CYCLES (`CNS_SEC_NS / `CNS_CLK_NS)

`define CNS_NUNITS 4
`define CNS_ID_MIN 3'h1
`define CNS_ID_MAX 3'h4

`endif

// ### logic/cns_pkg.sv
package cns_pkg;
  typedef enum logic [1:0] {CNS_ST_ON, CNS_ST_OFF, CNS_ST_ERR, CNS_ST_NONE}
    cns_status_t;
  typedef enum logic {CNS_NET_IDLE, CNS_NET_RUN} cns_net_t;
endpackage

// ### logic/cns_sched.sv
// Notes on behaviour
// - Each identifier slot reports running, stopped, fatal error or absent.
// - Fatal unit leaves algorithm; after clear, rejoins on manual start or on a good exchange while running.
// - Lost slave communication raises non-critical communication error E45.
// - Comm loss keeps status; later good exchange readmits a running unit.
// - After power returns, network restarts only if restart enabled.
// - With takeover on, highest-identifier slave takes master role on loss.
// - Watchdog times since last master packet; over limit, go automatic.
// - Sequential mode rotates limit pairs each rotation interval.
// - Rotation countdown runs only while network runs; value is kept.
// - Rotation never stops a unit; only active units rotate.
// - Each active unit takes next lower active unit's pair, cyclically.
// - Sequential reconfiguration: stopped unit gets lowest pair, the unit that held it takes the freed pair.
// - Cascade keeps pairs fixed to identifiers; interval ignored.
// - Cascade reconfiguration: stopped unit lowest, lower pairs move up.
// - Configured delay between successive compressor starts.
// - Algorithm type and network-on come from settings.
// - Commands come from master pressure and each unit's pair.
// - Time to rotation shows only in sequential mode.
// - Identifiers unique; link settings match on every controller.
// - Setting decides whether own compressor joins the algorithm.
// - Only identifiers one to four, without duplicates, participate.
// - Units found by search are admitted without halting the network.
// - Load below lower limit, unload above upper limit.
`timescale 1ns/10ps
`include "cns_consts.svh"

module cns_sched
  import cns_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `CNS_TICK_CYCLES
)
(
  input wire logic CLK, // System clock
  input wire logic RSTN, // Async reset, active low
  input wire logic HSEL, // AHB select
  input wire logic [31:0] HADDR, // AHB address
  input wire logic [1:0] HTRANS, // AHB transfer type
  input wire logic HWRITE, // AHB write
  input wire logic [2:0] HSIZE, // AHB size
  input wire logic [31:0] HWDATA, // AHB write data
  input wire logic HREADY, // AHB bus ready
  output logic [31:0] HRDATA, // AHB read data
  output logic HREADYOUT, // AHB slave ready
  output logic HRESP, // AHB response
  input wire logic [15:0] PRESSURE, // Own pressure measurement
  input wire logic [3:0] UNIT_PRESENT, // Unit found by search, per id
  input wire logic [3:0] UNIT_RUNNING, // Unit reports running
  input wire logic [3:0] UNIT_FATAL, // Unit reports fatal error
  input wire logic [3:0] UNIT_MANUAL_STOP, // Unit stopped by hand, pulse
  input wire logic [3:0] COMM_OK, // Good exchange with unit, pulse
  input wire logic [3:0] COMM_FAIL, // Failed exchange with unit, pulse
  input wire logic MASTER_PACKET, // Packet from master seen, pulse
  input wire logic MASTER_LOST, // Master link lost, level
  input wire logic POWER_RESTORED, // Power returned after failure, pulse
  output logic [3:0] LOAD_CMD, // Load command per unit
  output logic NET_RUNNING, // Network operation active
  output logic COMM_ERROR, // Communication error E45
  output logic TAKE_MASTER, // Assume master role
  output logic AUTO_FALLBACK // Slave falls back to automatic mode
);

  localparam int N = `CNS_NUNITS;

  logic [11:0] ctrl;
  logic [15:0] rot_int, start_dly, wd_limit;
  logic [15:0] lower [N];
  logic [15:0] upper [N];
  logic [1:0] base_pair [N];
  logic [1:0] eff_pair [N];
  logic [1:0] rot_pair [N];
  logic [1:0] pair_rank [N];
  logic [1:0] unit_rank [N];
  logic [3:0] member, started, unit_start;
  cns_net_t net;
  cns_status_t slot [N];
  logic [15:0] ttr, dly_cnt, wd_cnt;
  logic [27:0] pre_cnt;
  logic tick;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic start_ev, stop_ev;
  logic [2:0] own_id;
  logic own_ok;
  logic [1:0] own_idx;
  logic [3:0] own_mask;
  logic rotate;

  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // Bus address phase
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= HSEL & HREADY & HTRANS[1] & HWRITE;
      wr_addr <= HADDR[7:0];
    end
  end

  logic wr_ctrl;
  assign wr_ctrl = wr_pend & (wr_addr == `CNS_A_CTRL);
  assign start_ev = (wr_ctrl & HWDATA[`CNS_B_START] & HWDATA[`CNS_B_NET_ON])
    | (POWER_RESTORED & ctrl[`CNS_B_RESTART] & ctrl[`CNS_B_NET_ON]);
  assign stop_ev = (wr_ctrl & HWDATA[`CNS_B_STOP])
    | ~ctrl[`CNS_B_NET_ON];
  assign unit_start = (wr_pend & (wr_addr == `CNS_A_USTART)) ?
    HWDATA[3:0] : 4'h0;

  // Settings registers
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ctrl <= `CNS_CTRL_RST;
      rot_int <= `CNS_ROT_RST;
      start_dly <= `CNS_SDLY_RST;
      wd_limit <= `CNS_WDL_RST;
      for (int i = 0; i < N; i++)
      begin
        lower[i] <= 16'h0000;
        upper[i] <= 16'h0000;
      end
    end
    else if (wr_pend)
    begin
      case (wr_addr)
        `CNS_A_CTRL: ctrl <= {HWDATA[`CNS_ID_MSB:`CNS_ID_LSB], 2'b00,
          HWDATA[`CNS_B_WD_EN:0]};
        `CNS_A_ROT: rot_int <= HWDATA[15:0];
        `CNS_A_SDLY: start_dly <= HWDATA[15:0];
        `CNS_A_WDL: wd_limit <= HWDATA[15:0];
        `CNS_A_LIM0, `CNS_A_LIM1, `CNS_A_LIM2, `CNS_A_LIM3:
        begin
          lower[wr_addr[3:2]] <= HWDATA[15:0];
          upper[wr_addr[3:2]] <= HWDATA[31:16];
        end
        default: ;
      endcase
    end
  end

  // Own identifier range check
  assign own_id = ctrl[`CNS_ID_MSB:`CNS_ID_LSB];
  assign own_ok = (own_id >= `CNS_ID_MIN)
    && (own_id <= `CNS_ID_MAX);
  assign own_idx = 2'(own_id - 3'h1);
  assign own_mask = (own_ok && !ctrl[`CNS_B_INCL]) ?
    4'(4'h1 << own_idx) : 4'h0;

  // One-second tick
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      pre_cnt <= 28'h0000000;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (pre_cnt == 28'(TICK_CYCLES - 1));
      pre_cnt <= (pre_cnt == 28'(TICK_CYCLES - 1)) ? 28'h0000000 :
        pre_cnt + 28'h0000001;
    end
  end

  // Network run state
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      net <= CNS_NET_IDLE;
    else
    begin
      case (net)
        CNS_NET_IDLE: if (start_ev) net <= CNS_NET_RUN;
        CNS_NET_RUN: if (stop_ev || (member == 4'h0 && !start_ev))
          net <= CNS_NET_IDLE;
        default: net <= CNS_NET_IDLE;
      endcase
    end
  end
  assign NET_RUNNING = (net == CNS_NET_RUN);

  // Algorithm membership
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      member <= 4'h0;
    else if (start_ev && net == CNS_NET_IDLE)
      member <= UNIT_PRESENT & ~UNIT_FATAL & ~own_mask;
    else if (net != CNS_NET_RUN)
      member <= 4'h0;
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        if (UNIT_FATAL[i] || UNIT_MANUAL_STOP[i] || own_mask[i])
          member[i] <= 1'b0;
        else if (UNIT_PRESENT[i] && (unit_start[i]
                 || (COMM_OK[i] && UNIT_RUNNING[i])))
          member[i] <= 1'b1;
      end
    end
  end

  // Pair ranking, rank 0 holds the highest lower limit
  always_comb
  begin
    for (int p = 0; p < N; p++)
    begin
      pair_rank[p] = 2'd0;
      for (int q = 0; q < N; q++)
        if (q != p && (lower[q] > lower[p] || (lower[q] == lower[p] && q < p)))
          pair_rank[p] = pair_rank[p] + 2'd1;
    end
  end

  // Effective assignment with reconfiguration
  always_comb
  begin
    logic [2:0] nact;
    logic [1:0] r;
    logic [1:0] m;
    logic [1:0] cnt;
    logic [3:0] held;
    nact = 3'd0;
    r = 2'd0;
    m = 2'd0;
    cnt = 2'd0;
    held = 4'h0;
    for (int v = 0; v < N; v++)
    begin
      unit_rank[v] = pair_rank[base_pair[v]];
      nact = nact + {2'b00, member[v]};
      if (member[v])
        held[unit_rank[v]] = 1'b1;
    end
    for (int u = 0; u < N; u++)
    begin
      r = unit_rank[u];
      if (ctrl[`CNS_B_RECONF] && !member[u])
      begin
        r = nact[1:0];
        for (int v = 0; v < N; v++)
          if (!member[v] && unit_rank[v] < unit_rank[u])
            r = r + 2'd1;
      end
      else if (ctrl[`CNS_B_RECONF] && !ctrl[`CNS_B_SEQ])
      begin
        // Cascade: active units below a dropped one move up a place
        r = 2'd0;
        for (int v = 0; v < N; v++)
          if (member[v] && unit_rank[v] < unit_rank[u])
            r = r + 2'd1;
      end
      else if (ctrl[`CNS_B_RECONF] && {1'b0, unit_rank[u]} >= nact)
      begin
        // Sequential: a displaced active unit takes a freed upper pair
        m = 2'd0;
        for (int v = 0; v < N; v++)
          if (member[v] && {1'b0, unit_rank[v]} >= nact
              && unit_rank[v] < unit_rank[u])
            m = m + 2'd1;
        cnt = 2'd0;
        for (int q = 0; q < N; q++)
          if (3'(q) < nact && !held[q])
          begin
            if (cnt == m)
              r = 2'(q);
            cnt = cnt + 2'd1;
          end
      end
      eff_pair[u] = base_pair[u];
      for (int p = 0; p < N; p++)
        if (pair_rank[p] == r)
          eff_pair[u] = 2'(p);
    end
  end

  // Cyclic shift among active units
  always_comb
  begin
    logic found;
    logic [1:0] j;
    found = 1'b0;
    j = 2'd0;
    for (int i = 0; i < N; i++)
    begin
      rot_pair[i] = eff_pair[i];
      found = 1'b0;
      for (int k = 1; k < N; k++)
      begin
        j = 2'(i - k);
        if (member[i] && !found && member[j])
        begin
          rot_pair[i] = eff_pair[j];
          found = 1'b1;
        end
      end
    end
  end

  assign rotate = (net == CNS_NET_RUN) && ctrl[`CNS_B_SEQ] && tick
    && (ttr <= 16'h0001);

  // Rotation countdown and stored assignment
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ttr <= `CNS_TTR_RST;
      for (int i = 0; i < N; i++)
        base_pair[i] <= 2'(i);
    end
    else if (rotate)
    begin
      ttr <= rot_int;
      for (int i = 0; i < N; i++)
        base_pair[i] <= rot_pair[i];
    end
    else if ((net == CNS_NET_RUN) && ctrl[`CNS_B_SEQ] && tick)
      ttr <= ttr - 16'h0001;
    else if (!ctrl[`CNS_B_SEQ])
    begin
      // Cascade pins every pair to its own identifier
      for (int i = 0; i < N; i++)
        base_pair[i] <= 2'(i);
    end
  end

  // Staggered starts
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      started <= 4'h0;
      dly_cnt <= 16'h0000;
    end
    else if (net != CNS_NET_RUN)
    begin
      started <= 4'h0;
      dly_cnt <= 16'h0000;
    end
    else if (dly_cnt == 16'h0000 && (member & ~started) != 4'h0)
    begin
      started <= (started & member)
        | ((member & ~started) & ~((member & ~started) - 4'h1));
      dly_cnt <= start_dly;
    end
    else
    begin
      started <= started & member;
      if (tick && dly_cnt != 16'h0000)
        dly_cnt <= dly_cnt - 16'h0001;
    end
  end

  // Load and unload commands from own pressure
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      LOAD_CMD <= 4'h0;
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        if (!(member[i] && started[i]))
          LOAD_CMD[i] <= 1'b0;
        else if (PRESSURE < lower[eff_pair[i]])
          LOAD_CMD[i] <= 1'b1;
        else if (PRESSURE > upper[eff_pair[i]])
          LOAD_CMD[i] <= 1'b0;
      end
    end
  end

  // Per-identifier status
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      if (!UNIT_PRESENT[i])
        slot[i] = CNS_ST_NONE;
      else if (UNIT_FATAL[i])
        slot[i] = CNS_ST_ERR;
      else if (UNIT_RUNNING[i])
        slot[i] = CNS_ST_ON;
      else
        slot[i] = CNS_ST_OFF;
    end
  end

  // Communication error, a new failure wins over a clear
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      COMM_ERROR <= 1'b0;
    else if (|COMM_FAIL)
      COMM_ERROR <= 1'b1;
    else if (|COMM_OK)
      COMM_ERROR <= 1'b0;
  end

  // Master takeover and slave watchdog
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      TAKE_MASTER <= 1'b0;
    else
      TAKE_MASTER <= ctrl[`CNS_B_TAKEOVER] & MASTER_LOST & own_ok
        & ((UNIT_PRESENT >> own_id) == 4'h0);
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      wd_cnt <= 16'h0000;
      AUTO_FALLBACK <= 1'b0;
    end
    else if (!ctrl[`CNS_B_WD_EN] || MASTER_PACKET)
    begin
      wd_cnt <= 16'h0000;
      AUTO_FALLBACK <= 1'b0;
    end
    else
    begin
      if (tick && wd_cnt != 16'hFFFF)
        wd_cnt <= wd_cnt + 16'h0001;
      if (wd_cnt > wd_limit)
        AUTO_FALLBACK <= 1'b1;
    end
  end

  // Read data, registered in the address phase
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      HRDATA <= 32'h00000000;
    else if (HSEL && HREADY && HTRANS[1] && !HWRITE)
    begin
      case (HADDR[7:0])
        `CNS_A_CTRL: HRDATA <= {20'h00000, ctrl};
        `CNS_A_ROT: HRDATA <= {16'h0000, rot_int};
        `CNS_A_SDLY: HRDATA <= {16'h0000, start_dly};
        `CNS_A_WDL: HRDATA <= {16'h0000, wd_limit};
        `CNS_A_LIM0, `CNS_A_LIM1, `CNS_A_LIM2, `CNS_A_LIM3:
          HRDATA <= {upper[HADDR[3:2]], lower[HADDR[3:2]]};
        `CNS_A_STAT: HRDATA <= {(ctrl[`CNS_B_SEQ] ? ttr : 16'h0000),
          member, AUTO_FALLBACK, TAKE_MASTER, NET_RUNNING, COMM_ERROR,
          slot[3], slot[2], slot[1], slot[0]};
        `CNS_A_ASGN: HRDATA <= {24'h000000, eff_pair[3], eff_pair[2],
          eff_pair[1], eff_pair[0]};
        default: HRDATA <= 32'h00000000;
      endcase
    end
    else
      HRDATA <= 32'h00000000;
  end

endmodule

// ### tb/cns_sched_props.sv
`timescale 1ns/10ps
module cns_sched_props (
  input wire logic CLK, // System clock
  input wire logic RSTN, // Async reset, active low
  input wire logic HSEL, // Bus select
  input wire logic [1:0] HTRANS, // Transfer type
  input wire logic HWRITE, // Write transfer
  input wire logic HREADY, // Bus ready
  input wire logic [31:0] HRDATA, // Read data
  input wire logic HREADYOUT, // Slave ready
  input wire logic HRESP, // Slave response
  input wire logic [3:0] COMM_OK, // Good exchange pulses
  input wire logic [3:0] COMM_FAIL, // Failed exchange pulses
  input wire logic MASTER_PACKET, // Master packet pulse
  input wire logic MASTER_LOST, // Master link lost
  input wire logic POWER_RESTORED, // Power back pulse
  input wire logic NET_RUNNING, // Network active
  input wire logic COMM_ERROR, // Communication error
  input wire logic TAKE_MASTER, // Master role taken
  input wire logic AUTO_FALLBACK // Automatic fallback
);
  logic rd_phase;
  logic [2:0] since_cause;

  // Marks the data phase of an accepted read
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      rd_phase <= 1'b0;
    else
      rd_phase <= HSEL && HREADY && HTRANS[1] && !HWRITE;
  end

  // Cycles since the last bus write or power return, saturating
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      since_cause <= 3'h7;
    else if (POWER_RESTORED || (HSEL && HREADY && HTRANS[1] && HWRITE))
      since_cause <= 3'h0;
    else if (since_cause != 3'h7)
      since_cause <= since_cause + 3'h1;
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);

  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("slave not ready or response not okay");
  a_rdata_idle: assert property (!rd_phase |-> HRDATA == 32'h0)
    else $error("read data outside a read data phase");
  a_err_on_fail: assert property (|COMM_FAIL |=> COMM_ERROR)
    else $error("failed exchange did not raise the error");
  a_err_clear_ok: assert property (
    (|COMM_OK && !(|COMM_FAIL)) |=> !COMM_ERROR)
    else $error("good exchange did not clear the error");
  a_take_needs_lost: assert property (
    TAKE_MASTER |-> $past(MASTER_LOST))
    else $error("master role taken without link loss");
  a_take_drops: assert property (!MASTER_LOST |=> !TAKE_MASTER)
    else $error("master role held with master present");
  a_fallback_fresh: assert property (
    MASTER_PACKET |-> ##2 !$rose(AUTO_FALLBACK))
    else $error("fallback right after a master packet");
  a_start_cause: assert property (
    $rose(NET_RUNNING) |-> since_cause <= 3'h4)
    else $error("network started without a cause");
endmodule

// ### tb/cns_far_units.sv
`timescale 1ns/10ps
module cns_far_units (
  input wire logic CLK, // System clock
  input wire logic [3:0] LOAD_CMD, // Commands from master
  output logic [3:0] UNIT_PRESENT, // Units on the link
  output logic [3:0] UNIT_RUNNING, // Units running
  output logic [3:0] UNIT_FATAL, // Units in fatal error
  output logic [3:0] UNIT_MANUAL_STOP, // Stop by hand, pulse
  output logic [3:0] COMM_OK, // Good exchange, pulse
  output logic [3:0] COMM_FAIL, // Failed exchange, pulse
  output logic MASTER_PACKET, // Master packet, pulse
  output logic MASTER_LOST, // Master link down
  output logic [3:0] COMPRESSING // Units compressing now
);
  // Remote units follow the command only, never their own limits
  assign COMPRESSING = LOAD_CMD & UNIT_RUNNING & ~UNIT_FATAL;

  initial
  begin
    {UNIT_PRESENT, UNIT_RUNNING, UNIT_FATAL, UNIT_MANUAL_STOP} = 16'h0;
    {COMM_OK, COMM_FAIL, MASTER_PACKET, MASTER_LOST} = 10'h0;
  end

  // Identifiers 1..4 map one to one onto bits, so none repeats
  task set_units(input logic [3:0] p, r, f);
    @(posedge CLK);
    UNIT_PRESENT <= p;
    UNIT_RUNNING <= r;
    UNIT_FATAL <= f;
  endtask

  task pulse(input logic [3:0] ok, fail, stop, input logic pkt);
    @(posedge CLK);
    COMM_OK <= ok;
    COMM_FAIL <= fail;
    UNIT_MANUAL_STOP <= stop;
    MASTER_PACKET <= pkt;
    @(posedge CLK);
    {COMM_OK, COMM_FAIL, UNIT_MANUAL_STOP, MASTER_PACKET} <= 13'h0;
  endtask

  task lose_master(input logic l);
    @(posedge CLK);
    MASTER_LOST <= l;
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/10ps
`include "cns_consts.svh"
module testbench;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} cns_row_t;
  logic CLK = 1'b0, RSTN = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, r;
  logic [1:0] HTRANS = 2'h0;
  logic [2:0] HSIZE = 3'h2;
  logic [15:0] PRESSURE = 16'h50, ttr_kept;
  logic HREADYOUT, HRESP, MASTER_PACKET, MASTER_LOST;
  logic POWER_RESTORED = 1'b0;
  logic NET_RUNNING, COMM_ERROR, TAKE_MASTER, AUTO_FALLBACK;
  logic [3:0] UNIT_PRESENT, UNIT_RUNNING, UNIT_FATAL, UNIT_MANUAL_STOP;
  logic [3:0] COMM_OK, COMM_FAIL, LOAD_CMD;
  int num_errors = 0, samples_checked = 0;
  cns_row_t rows [18] = '{'{1'b0, `CNS_A_CTRL, 32'h2},
    '{1'b0, `CNS_A_ROT, 32'hE10}, '{1'b0, `CNS_A_SDLY, 32'hA},
    '{1'b0, `CNS_A_WDL, 32'h3C}, '{1'b0, `CNS_A_ASGN, 32'hE4},
    '{1'b0, `CNS_A_STAT, 32'hE1000FF}, '{1'b0, 8'h20, 32'h0},
    '{1'b1, 8'h20, 32'hFFFFFFFF}, '{1'b0, 8'h20, 32'h0},
    '{1'b1, `CNS_A_LIM0, 32'h47003C}, '{1'b1, `CNS_A_LIM1, 32'h3D0032},
    '{1'b1, `CNS_A_LIM2, 32'h330028}, '{1'b1, `CNS_A_LIM3, 32'h29001E},
    '{1'b0, `CNS_A_LIM3, 32'h29001E}, '{1'b1, `CNS_A_ROT, 32'h2},
    '{1'b0, `CNS_A_ROT, 32'h2}, '{1'b1, `CNS_A_SDLY, 32'h1},
    '{1'b1, `CNS_A_WDL, 32'h2}};

  always #2 CLK = ~CLK;

  cns_sched #(.TICK_CYCLES(4)) i_dut (.CLK(CLK), .RSTN(RSTN), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .PRESSURE(PRESSURE),
    .UNIT_PRESENT(UNIT_PRESENT), .UNIT_RUNNING(UNIT_RUNNING),
    .UNIT_FATAL(UNIT_FATAL), .UNIT_MANUAL_STOP(UNIT_MANUAL_STOP),
    .COMM_OK(COMM_OK), .COMM_FAIL(COMM_FAIL), .MASTER_PACKET(MASTER_PACKET),
    .MASTER_LOST(MASTER_LOST), .POWER_RESTORED(POWER_RESTORED),
    .LOAD_CMD(LOAD_CMD), .NET_RUNNING(NET_RUNNING), .COMM_ERROR(COMM_ERROR),
    .TAKE_MASTER(TAKE_MASTER), .AUTO_FALLBACK(AUTO_FALLBACK));

  cns_far_units i_far (.CLK(CLK), .LOAD_CMD(LOAD_CMD),
    .UNIT_PRESENT(UNIT_PRESENT), .UNIT_RUNNING(UNIT_RUNNING),
    .UNIT_FATAL(UNIT_FATAL), .UNIT_MANUAL_STOP(UNIT_MANUAL_STOP),
    .COMM_OK(COMM_OK), .COMM_FAIL(COMM_FAIL), .MASTER_PACKET(MASTER_PACKET),
    .MASTER_LOST(MASTER_LOST), .COMPRESSING());

  task check(input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task tally_and_finish;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One single transfer; read data lands in r
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    r = HRDATA;
  endtask

  task tick(input int n);
    repeat (n) @(posedge CLK);
  endtask

  task power_back;
    @(posedge CLK);
    POWER_RESTORED <= 1'b1;
    @(posedge CLK);
    POWER_RESTORED <= 1'b0;
    tick(4);
  endtask

  initial
  begin
    #200000;
    num_errors++;
    tally_and_finish;
  end

  initial
  begin
    tick(5);
    RSTN <= 1'b1;
    foreach (rows[i])
    begin
      ahb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        check(r, rows[i].d);
    end
    i_far.set_units(4'hF, 4'hF, 4'h0);
    ahb(1'b1, `CNS_A_CTRL, 32'h87);
    tick(3);
    check(NET_RUNNING, 1'b1);
    PRESSURE <= 16'h23;
    tick(2);
    check($countones(LOAD_CMD) < 2, 1'b1);
    tick(40);
    check(LOAD_CMD, 4'h7);
    PRESSURE <= 16'h50;
    tick(3);
    check(LOAD_CMD, 4'h0);
    ahb(1'b0, `CNS_A_STAT, 32'h0);
    ahb(1'b1, `CNS_A_CTRL, 32'h107);
    tick(3);
    ahb(1'b0, `CNS_A_STAT, 32'h0);
    ttr_kept = r[31:16];
    tick(20);
    ahb(1'b0, `CNS_A_STAT, 32'h0);
    check(r[31:16], ttr_kept);
    check(ttr_kept < 16'hE10, 1'b1);
    ahb(1'b1, `CNS_A_CTRL, 32'h87);
    i_far.pulse(4'h0, 4'h0, 4'h2, 1'b0);
    i_far.set_units(4'hF, 4'hD, 4'h0);
    tick(4);
    ahb(1'b0, `CNS_A_ASGN, 32'h0);
    check(r, 32'h6C);
    ahb(1'b0, `CNS_A_STAT, 32'h0);
    check(r[15:0], 16'hD204);
    repeat (6000)
      if (r[7:0] == 8'h04 || r[7:0] == 8'h6C)
        ahb(1'b0, `CNS_A_ASGN, 32'h0);
    check(r, 32'h8D);
    i_far.set_units(4'hF, 4'hF, 4'h0);
    ahb(1'b1, `CNS_A_USTART, 32'h2);
    tick(3);
    ahb(1'b0, `CNS_A_STAT, 32'h0);
    check(r[15:12], 4'hF);
    i_far.pulse(4'h0, 4'h1, 4'h0, 1'b0);
    tick(1);
    check(COMM_ERROR, 1'b1);
    ahb(1'b0, `CNS_A_STAT, 32'h0);
    check(r[7:0], 8'h0);
    i_far.pulse(4'h1, 4'h0, 4'h0, 1'b0);
    tick(1);
    check(COMM_ERROR, 1'b0);
    ahb(1'b1, `CNS_A_CTRL, 32'h85);
    i_far.set_units(4'hF, 4'hF, 4'h2);
    tick(4);
    ahb(1'b0, `CNS_A_ASGN, 32'h0);
    check(r, 32'h9C);
    ahb(1'b0, `CNS_A_STAT, 32'h0);
    check({r[31:16], r[3:2]}, 18'h2);
    i_far.set_units(4'hF, 4'hF, 4'h0);
    ahb(1'b1, `CNS_A_USTART, 32'h2);
    tick(40);
    ahb(1'b0, `CNS_A_ASGN, 32'h0);
    check(r, 32'hE4);
    ahb(1'b1, `CNS_A_CTRL, 32'h810);
    i_far.lose_master(1'b1);
    tick(3);
    check(TAKE_MASTER, 1'b1);
    ahb(1'b1, `CNS_A_CTRL, 32'h410);
    tick(3);
    check(TAKE_MASTER, 1'b0);
    i_far.lose_master(1'b0);
    ahb(1'b1, `CNS_A_CTRL, 32'h40);
    i_far.pulse(4'h0, 4'h0, 4'h0, 1'b1);
    tick(4);
    check(AUTO_FALLBACK, 1'b0);
    tick(40);
    check(AUTO_FALLBACK, 1'b1);
    ahb(1'b1, `CNS_A_CTRL, 32'h3);
    power_back();
    check(NET_RUNNING, 1'b0);
    ahb(1'b1, `CNS_A_CTRL, 32'hB);
    power_back();
    check(NET_RUNNING, 1'b1);
    ahb(1'b1, `CNS_A_CTRL, 32'h20B);
    ahb(1'b0, `CNS_A_STAT, 32'h0);
    check(r[15:12], 4'hE);
    tally_and_finish;
  end
endmodule

bind cns_sched cns_sched_props i_props (.CLK(CLK), .RSTN(RSTN),
  .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .COMM_OK(COMM_OK), .COMM_FAIL(COMM_FAIL), .MASTER_PACKET(MASTER_PACKET),
  .MASTER_LOST(MASTER_LOST), .POWER_RESTORED(POWER_RESTORED),
  .NET_RUNNING(NET_RUNNING), .COMM_ERROR(COMM_ERROR),
  .TAKE_MASTER(TAKE_MASTER), .AUTO_FALLBACK(AUTO_FALLBACK));
